// ### sim/tb.sv
/*
  Self-checking bench of the timer interrupt-enable block.
  Assumes the host model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import tcie_pkg::*;
;
  logic        clk_sys = 0, resetn = 0, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
  logic [3:0]  avs_byteenable = 4'hF;
  bit          lane_off = 1'b0; // Lane 0 off for a refused write
  logic [6:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic [35:0] ev = '0, req;
  logic [5:0]  conv;
  int          err_count = 0, checked = 0, conv_seen;
  // Clock and parts
  always #2.5 clk_sys = ~clk_sys;
  tcie_top i_tcie_top (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .ovf_wrap(ev[5:0]), .unf_wrap(ev[11:6]), .gen_reg_a_evt(ev[17:12]),
    .gen_reg_b_evt(ev[23:18]), .gen_reg_c_evt(ev[29:24]), .gen_reg_d_evt(ev[35:30]),
    .overflow_irq(req[5:0]), .underflow_irq(req[11:6]), .gen_reg_a_irq(req[17:12]),
    .gen_reg_b_irq(req[23:18]), .gen_reg_c_irq(req[29:24]), .gen_reg_d_irq(req[35:30]),
    .conv_start_req(conv), .irq);
  tcie_host_model i_tcie_host_model (.clk_sys, .resetn, .conv_start_req(conv), .conv_seen);
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle, held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= {24'h00_0000, d};
    avs_byteenable <= lane_off ? 4'hE : 4'hF;
    avs_write      <= w;
    avs_read       <= !w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      $display("mismatch at %0t: bus hang", $time);
      report_and_stop();
    end else begin
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      #1;
    end
  endtask
  // Event pulse of one cycle, then request settles
  task automatic fire(input logic [35:0] v);
    @(posedge clk_sys);
    ev <= v;
    @(posedge clk_sys);
    ev <= '0;
    @(posedge clk_sys);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int c = 0; c < NCH; c++) begin
      bus(0, 7'(c * 4), 8'h00);
      chk(36'(q), 36'h0_0000_0040);
      bus(0, 7'(32 + c * 4), 8'h00);
      chk(36'(q), 36'h0_0000_00C0);
    end
    chk(req, 36'h0_0000_0000);
    $display("test reset done");
  endtask
  task automatic t_access;
    bit cd;
    for (int c = 0; c < NCH; c++) begin
      cd = (c == 0 || c == 3);
      bus(1, 7'(c * 4), 8'h00);
      bus(0, 7'(c * 4), 8'h00);
      chk(36'(q), 36'h0_0000_0040);
      bus(1, 7'(c * 4), 8'hFF);
      bus(0, 7'(c * 4), 8'h00);
      chk(36'(q), cd ? 36'h0_0000_00DF : 36'h0_0000_00F3);
    end
    lane_off = 1'b1;
    bus(1, 7'h04, 8'h00);
    lane_off = 1'b0;
    bus(0, 7'h04, 8'h00);
    chk(36'(q), 36'h0_0000_00F3);
    bus(1, 7'h60, 8'hFF);
    bus(0, 7'h60, 8'h00);
    chk(36'(q), 36'h0_0000_0000);
    $display("test access done");
  endtask
  task automatic t_gates;
    fire(36'hF_FFFF_FFFF);
    chk(req, {6'h09, 6'h09, 6'h3F, 6'h3F, 6'h36, 6'h3F});
    chk(36'(conv_seen), 36'h0_0000_0006);
    bus(1, 7'h24, 8'h00);
    chk(req, {6'h09, 6'h09, 6'h3F, 6'h3F, 6'h36, 6'h3F});
    bus(0, 7'h28, 8'h00);
    chk(36'(q), 36'h0_0000_00F3);
    bus(1, 7'h28, 8'h00);
    chk(req, {6'h09, 6'h09, 6'h3B, 6'h3B, 6'h32, 6'h3B});
    bus(1, 7'h00, 8'h00);
    chk(req, {6'h08, 6'h08, 6'h3A, 6'h3A, 6'h32, 6'h3A});
    bus(1, 7'h00, 8'h10);
    chk(req, {6'h08, 6'h08, 6'h3A, 6'h3A, 6'h32, 6'h3B});
    fire(36'h0_0000_1000);
    chk(36'(conv_seen), 36'h0_0000_0006);
    fire(36'h0_0000_2000);
    chk(36'(conv_seen), 36'h0_0000_0007);
    $display("test gates done");
  endtask
  task automatic t_irq;
    chk(36'(irq), 36'h0_0000_0000);
    bus(1, 7'h44, 8'h04);
    chk(36'(irq), 36'h0_0000_0001);
    bus(0, 7'h44, 8'h00);
    chk(36'(q), 36'h0_0000_0004);
    bus(1, 7'h40, 8'h04);
    chk(36'(irq), 36'h0_0000_0000);
    bus(1, 7'h44, 8'h01);
    bus(1, 7'h40, 8'h01);
    chk(36'(irq), 36'h0_0000_0001);
    bus(0, 7'h40, 8'h00);
    chk(36'(q), 36'h0_0000_003B);
    $display("test irq done");
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1;
    t_reset();
    t_access();
    t_gates();
    t_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### sim/tcie_host_model.sv
/*
  Converter trigger input at the far side: counts conversion starts.
  Assumes one-cycle start pulses on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module tcie_host_model
  import tcie_pkg::*;
(
  input wire logic           clk_sys,
  input wire logic           resetn,
  input wire logic [NCH-1:0] conv_start_req,
  output var int             conv_seen
);
  // Each high bit is one accepted start
  always_ff @(posedge clk_sys) begin
    if (!resetn) conv_seen <= 0;
    else conv_seen <= conv_seen + $countones(conv_start_req);
  end
endmodule
`default_nettype wire

// ### sim/tcie_sva.sv
/*
  Port checker for the timer interrupt-enable top, bound to tcie_top.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tcie_sva
  import tcie_pkg::*;
(
  input wire logic           clk_sys,
  input wire logic           resetn,
  input wire logic           avs_read,
  input wire logic           avs_write,
  input wire logic           avs_waitrequest,
  input wire logic [NCH-1:0] ovf_wrap,
  input wire logic [NCH-1:0] gen_reg_a_evt,
  input wire logic [NCH-1:0] overflow_irq,
  input wire logic [NCH-1:0] underflow_irq,
  input wire logic [NCH-1:0] gen_reg_a_irq,
  input wire logic [NCH-1:0] gen_reg_c_irq,
  input wire logic [NCH-1:0] gen_reg_d_irq,
  input wire logic [NCH-1:0] conv_start_req,
  input wire logic           irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic wacc;
  // Write accepted in this cycle
  assign wacc = avs_write & ~avs_waitrequest;
  ////////////////////////////////////////////////////////////////////////
  a_conv_has_cause: assert property (conv_start_req != 0 |->
    (conv_start_req & ~$past(gen_reg_a_evt)) == 0) else $error("conv without event");
  a_unf_ch_absent: assert property ((underflow_irq & ~CH_HAS_UNF) == 0)
    else $error("underflow request on channel without it");
  a_cd_ch_absent: assert property (((gen_reg_c_irq | gen_reg_d_irq) & ~CH_HAS_CD) == 0)
    else $error("C or D request on channel without it");
  a_ovf_rise_cause: assert property ((overflow_irq & ~$past(overflow_irq)) != 0 |->
    $past(ovf_wrap) != 0 || $past(ovf_wrap, 2) != 0 || $past(wacc)) else $error("overflow rose alone");
  a_ovf_fall_cause: assert property ((~overflow_irq & $past(overflow_irq)) != 0 |->
    $past(wacc)) else $error("overflow fell without write");
  a_gra_rise_cause: assert property ((gen_reg_a_irq & ~$past(gen_reg_a_irq)) != 0 |->
    $past(gen_reg_a_evt) != 0 || $past(gen_reg_a_evt, 2) != 0 || $past(wacc))
    else $error("register A request rose alone");
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("no answer after one wait state");
  a_bus_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  // Main scenarios reached
  c_conv: cover property (conv_start_req != 0);
  c_ovf: cover property ($rose(overflow_irq != 0));
  c_irq: cover property ($rose(irq));
endmodule
bind tcie_top tcie_sva i_tcie_sva (.clk_sys, .resetn, .avs_read, .avs_write, .avs_waitrequest,
  .ovf_wrap, .gen_reg_a_evt, .overflow_irq, .underflow_irq, .gen_reg_a_irq, .gen_reg_c_irq,
  .gen_reg_d_irq, .conv_start_req, .irq);
`default_nettype wire

// ### verilog/tcie_chan_if.sv
/*
  Link between the bus front and one channel slice.
  Assumes strobes are one-cycle pulses on the shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface tcie_chan_if;
  logic       en_we;   // Enable register write
  logic       st_we;   // Status register write
  logic       st_re;   // Status register read
  logic [7:0] wdata;
  logic [5:0] ev;      // Flag set events
  logic [7:0] en_rd;
  logic [7:0] st_rd;
  logic [5:0] req;     // Gated requests
  logic       conv;    // Conversion start pulse

  modport chan (input en_we, st_we, st_re, wdata, ev, output en_rd, st_rd, req, conv);
  modport front (output en_we, st_we, st_re, wdata, ev, input en_rd, st_rd, req, conv);
endinterface
`default_nettype wire

// ### verilog/tcie_channel.sv
/*
  One timer channel: enable register, status flags and request gating.
  Assumes strobes arrive already decoded and accepted by the bus front.
*/
`timescale 1ns/1ps
`default_nettype none
module tcie_channel
  import tcie_pkg::*;
#(
  parameter bit HAS_UNF = 1'b0,
  parameter bit HAS_CD  = 1'b0
) (
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  tcie_chan_if.chan   bus
);

  typedef struct packed {
    logic [7:0] en;
    logic [5:0] flags;
    logic [5:0] arm;
    logic [5:0] req;
    logic       conv;
  } tcie_ch_st_t;

  localparam logic [7:0] WR_MASK = en_wr_mask(HAS_UNF, HAS_CD);
  localparam logic [5:0] FL_MASK = FL_ALL | WR_MASK[5:0];
  localparam tcie_ch_st_t ST_RESET = '{EN_RESET, 6'h00, 6'h00, 6'h00, 1'b0};

  tcie_ch_st_t s_q;
  tcie_ch_st_t s_d;
  logic [5:0]  clr;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    clr = 6'h00;
    // Reserved bits keep their fixed value
    if (bus.en_we) begin
      s_d.en = (s_q.en & ~WR_MASK) | (bus.wdata & WR_MASK);
    end
    // Zero written over a flag read as one
    if (bus.st_we) begin
      clr = s_q.arm & ~bus.wdata[5:0];
      s_d.arm = 6'h00;
    end
    if (bus.st_re) begin
      s_d.arm = s_q.flags;
    end
    // Set wins over clear
    s_d.flags = ((s_q.flags & ~clr) | bus.ev) & FL_MASK;
    s_d.req = s_d.flags & s_d.en[5:0];
    s_d.conv = bus.ev[BIT_GA] & s_q.en[BIT_TRG];
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_q <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Readback and requests
  assign bus.en_rd = s_q.en;
  assign bus.st_rd = ST_FIXED | {2'b00, s_q.flags};
  assign bus.req   = s_q.req;
  assign bus.conv  = s_q.conv;

endmodule
`default_nettype wire

// ### verilog/tcie_pkg.sv
/*
  Constants of the six-channel timer interrupt-enable block: register map,
  bit positions, reset values and per-channel bit availability.
  Assumes a single clock domain and byte addresses on a 32-bit bus.
*/
// Summary of operation
// - Six independent 8-bit readable, writable enable registers, one per channel.
// - Bit 7 lets each register A capture/compare event request a conversion start.
// - Bit 6 is reserved, always reads 1, ignores writes.
// - Channels 1, 2, 4, 5: bit 5 enables the underflow request.
// - Channels 0 and 3: bit 5 reads 0 and cannot be written.
// - All channels: bit 4 enables the overflow request.
// - Channels 0 and 3: bit 3 enables the register D request.
// - Channels 1, 2, 4, 5: bit 3 reads 0 and cannot be written.
// - Channels 0 and 3: bit 2 enables the register C request.
// - Channels 1, 2, 4, 5: bit 2 reads 0 and cannot be written.
// - All channels: bit 1 enables the register B request.
// - All channels: bit 0 enables the register A request.
// - Overflow flag sets when the channel counter wraps from maximum to zero.
// - Underflow flag sets when the channel counter wraps from zero to maximum.
package tcie_pkg;

  localparam int NCH = 6;

  // Register map, byte addresses
  localparam logic [6:0] OFS_EN_BASE = 7'h00;
  localparam logic [6:0] OFS_ST_BASE = 7'h20;
  localparam logic [6:0] OFS_PEND    = 7'h40;
  localparam logic [6:0] OFS_MASK    = 7'h44;

  // Bit positions shared by enable and status registers
  localparam int BIT_GA  = 0;
  localparam int BIT_GB  = 1;
  localparam int BIT_GC  = 2;
  localparam int BIT_GD  = 3;
  localparam int BIT_OVF = 4;
  localparam int BIT_UNF = 5;
  localparam int BIT_TRG = 7;

  // Reset and fixed values
  localparam logic [7:0] EN_RESET  = 8'h40;
  localparam logic [7:0] EN_WR_ALL = 8'h93;
  localparam logic [7:0] EN_WR_UNF = 8'h20;
  localparam logic [7:0] EN_WR_CD  = 8'h0C;
  localparam logic [7:0] ST_FIXED  = 8'hC0;
  localparam logic [5:0] FL_ALL    = 6'h13;

  // Channels carrying underflow, and channels carrying C and D
  localparam logic [5:0] CH_HAS_UNF = 6'h36;
  localparam logic [5:0] CH_HAS_CD  = 6'h09;

  // Writable enable bits of a channel
  function automatic logic [7:0] en_wr_mask(input logic has_unf, input logic has_cd);
    en_wr_mask = EN_WR_ALL | (has_unf ? EN_WR_UNF : 8'h00) | (has_cd ? EN_WR_CD : 8'h00);
  endfunction

endpackage

// ### verilog/tcie_top.sv
/*
  Six-channel timer interrupt-enable block with Avalon-MM register slave,
  per-channel gated request lines, conversion start pulses and one
  summary interrupt with sticky pending and mask registers.
  Assumes event inputs are one-cycle pulses on clk_sys from the timer core.
*/
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tcie_top
  import tcie_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Avalon-MM slave
  input  wire logic [6:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output var  logic [31:0]      avs_readdata,
  output var  logic             avs_waitrequest,
  // Timer core events, one bit per channel
  input  wire logic [NCH-1:0]   ovf_wrap,
  input  wire logic [NCH-1:0]   unf_wrap,
  input  wire logic [NCH-1:0]   gen_reg_a_evt,
  input  wire logic [NCH-1:0]   gen_reg_b_evt,
  input  wire logic [NCH-1:0]   gen_reg_c_evt,
  input  wire logic [NCH-1:0]   gen_reg_d_evt,
  // Gated requests
  output var  logic [NCH-1:0]   overflow_irq,
  output var  logic [NCH-1:0]   underflow_irq,
  output var  logic [NCH-1:0]   gen_reg_a_irq,
  output var  logic [NCH-1:0]   gen_reg_b_irq,
  output var  logic [NCH-1:0]   gen_reg_c_irq,
  output var  logic [NCH-1:0]   gen_reg_d_irq,
  output var  logic [NCH-1:0]   conv_start_req,
  output var  logic             irq
);

  typedef struct packed {
    logic        wreq;
    logic [31:0] rdata;
    logic [5:0]  pend;
    logic [5:0]  mask;
    logic        irq;
  } tcie_top_st_t;

  localparam tcie_top_st_t ST_RESET = '{1'b1, 32'h0000_0000, 6'h00, 6'h00, 1'b0};

  tcie_top_st_t s_q;
  tcie_top_st_t s_d;

  tcie_chan_if ch_if [NCH] ();

  logic [7:0]     en_rb [NCH];
  logic [7:0]     st_rb [NCH];
  logic [NCH-1:0] ch_any;
  logic           take;
  logic           wr_go;
  logic           rd_go;
  logic           lane0;

  ////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // Channel register hit within a region
  function automatic logic ch_hit(input logic [6:0] addr, input logic [6:0] base,
                                  input int ch);
    ch_hit = (addr[6:5] == base[6:5]) && (addr[4:2] == 3'(ch));
  endfunction

  // Read data for an address
  function automatic logic [31:0] rd_word(input logic [6:0] addr,
                                          input logic [7:0] en_v [NCH],
                                          input logic [7:0] st_v [NCH],
                                          input logic [5:0] pend,
                                          input logic [5:0] mask);
    rd_word = 32'h0000_0000;
    for (int i = 0; i < NCH; i++) begin
      if (ch_hit(addr, OFS_EN_BASE, i)) begin
        rd_word = {24'h00_0000, en_v[i]};
      end
      if (ch_hit(addr, OFS_ST_BASE, i)) begin
        rd_word = {24'h00_0000, st_v[i]};
      end
    end
    if (addr[6:2] == OFS_PEND[6:2]) begin
      rd_word = {26'h000_0000, pend};
    end
    if (addr[6:2] == OFS_MASK[6:2]) begin
      rd_word = {26'h000_0000, mask};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake strobes

  // Request held while waitrequest low is the accepting edge
  assign take  = !s_q.wreq;
  assign wr_go = take && avs_write;
  assign rd_go = avs_read && s_q.wreq; // Arms from the flags the answer returns
  assign lane0 = avs_byteenable[0];

  ////////////////////////////////////////////////////////////////////////
  // Channel slices
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    // Strobes and events into the slice
    assign ch_if[g].en_we = wr_go && lane0 && ch_hit(avs_address, OFS_EN_BASE, g);
    assign ch_if[g].st_we = wr_go && lane0 && ch_hit(avs_address, OFS_ST_BASE, g);
    assign ch_if[g].st_re = rd_go && ch_hit(avs_address, OFS_ST_BASE, g);
    assign ch_if[g].wdata = avs_writedata[7:0];
    assign ch_if[g].ev = {unf_wrap[g], ovf_wrap[g], gen_reg_d_evt[g],
                          gen_reg_c_evt[g], gen_reg_b_evt[g], gen_reg_a_evt[g]};

    tcie_channel #(
      .HAS_UNF (CH_HAS_UNF[g]),
      .HAS_CD  (CH_HAS_CD[g])
    ) u_ch (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .bus     (ch_if[g])
    );

    // Readback and request fan-out
    assign en_rb[g]          = ch_if[g].en_rd;
    assign st_rb[g]          = ch_if[g].st_rd;
    assign ch_any[g]         = |ch_if[g].req;
    assign gen_reg_a_irq[g]  = ch_if[g].req[BIT_GA];
    assign gen_reg_b_irq[g]  = ch_if[g].req[BIT_GB];
    assign gen_reg_c_irq[g]  = ch_if[g].req[BIT_GC];
    assign gen_reg_d_irq[g]  = ch_if[g].req[BIT_GD];
    assign overflow_irq[g]   = ch_if[g].req[BIT_OVF];
    assign underflow_irq[g]  = ch_if[g].req[BIT_UNF];
    assign conv_start_req[g] = ch_if[g].conv;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state: bus answer, pending, mask, summary interrupt
  always_comb begin
    s_d = s_q;
    // One wait state, then one cycle with waitrequest low
    s_d.wreq = 1'b1;
    if ((avs_read || avs_write) && s_q.wreq) begin
      s_d.wreq  = 1'b0;
      s_d.rdata = rd_word(avs_address, en_rb, st_rb, s_q.pend, s_q.mask);
    end
    // Pending: write one clears, set wins
    s_d.pend = s_q.pend;
    if (wr_go && lane0 && (avs_address[6:2] == OFS_PEND[6:2])) begin
      s_d.pend = s_q.pend & ~avs_writedata[5:0];
    end
    s_d.pend = s_d.pend | ch_any;
    if (wr_go && lane0 && (avs_address[6:2] == OFS_MASK[6:2])) begin
      s_d.mask = avs_writedata[5:0];
    end
    s_d.irq = |(s_d.pend & s_d.mask);
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_q <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered bus and interrupt outputs
  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.wreq;
  assign irq             = s_q.irq;

endmodule
`default_nettype wire
